//--- shared/vector_select_defines.svh
// Constants for the reset and interrupt vector address generator
`ifndef VECTOR_SELECT_DEFINES_SVH
`define VECTOR_SELECT_DEFINES_SVH

`define VEC_ADDR_W 12
`define VEC_NUM_SRC 25
`define VEC_RESET_ADDR 12'h000
`define VEC_TABLE_BASE 12'h001
`define VEC_BOOT_RESET_ADDR 12'hC00
`define VEC_FUSE_UNPROGRAMMED 1'b1
// Settle count reached once the fuse synchroniser holds the real level
`define VEC_FUSE_SETTLE 2'h2

`endif

//--- shared/vector_select_pkg.sv
// Types for the reset and interrupt vector address generator
package vector_select_pkg;
  // Fetch redirect sequencer states
  typedef enum logic [1:0] {
    st_reset,
    st_idle,
    st_vector
  } vec_state_t;
  // One bit per interrupt source, bit 0 is the highest priority entry
  typedef logic [24:0] irq_vec_t;
  typedef logic [11:0] vec_addr_t;
endpackage : vector_select_pkg

//--- core/reset_interrupt_vector_select.sv
// Reset and interrupt vector address generator for the core fetch unit
`timescale 1ns/100ps
`include "vector_select_defines.svh"

module reset_interrupt_vector_select #(
  parameter int NUM_SRC = `VEC_NUM_SRC,                 // Interrupt table entries
  parameter logic [11:0] BOOT_START = `VEC_BOOT_RESET_ADDR // Boot flash section start
) (
  input wire logic sys_clk,                             // Core clock
  input wire logic rst_n,                               // Any system reset, low active
  input wire logic boot_reset_select_fuse,              // Fuse level, 0 = programmed
  input wire logic vector_table_select,                 // Control bit from core control reg
  input wire vector_select_pkg::irq_vec_t irq_pending,  // Enabled and flagged requests
  input wire logic irq_accept,                          // Core takes an interrupt now
  output logic fetch_redirect,                          // One-cycle: load vector_addr
  output vector_select_pkg::vec_addr_t vector_addr,     // Word address of the vector slot
  output logic reset_fetch,                             // Redirect is the reset vector
  output vector_select_pkg::irq_vec_t irq_taken         // One-hot source that was taken
);
  import vector_select_pkg::*;

  // Fuse is a static level from the nonvolatile array, double sampled anyway
  logic fuse_meta;
  logic fuse_sync;
  // Current and next sequencer state
  vec_state_t state;
  vec_state_t next_state;
  // Registered outputs and their next values
  logic next_fetch_redirect;
  vec_addr_t next_vector_addr;
  logic next_reset_fetch;
  irq_vec_t next_irq_taken;
  // Fuse captured after reset release
  logic fuse_held;
  logic next_fuse_held;
  // Edges counted after release while the fuse synchroniser fills
  logic [1:0] settle_cnt;
  logic [1:0] next_settle_cnt;
  // Priority encoder results
  logic [4:0] win_idx;
  logic win_any;

  // Two-flop synchroniser for the fuse level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_meta <= `VEC_FUSE_UNPROGRAMMED;
      fuse_sync <= `VEC_FUSE_UNPROGRAMMED;
    end else begin
      fuse_meta <= boot_reset_select_fuse;
      fuse_sync <= fuse_meta;
    end
  end

  // Lowest numbered pending request wins; later bits cannot override
  always_comb begin
    win_idx = 5'h00;
    win_any = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (irq_pending[i]) begin
        win_idx = 5'(i);
        win_any = 1'b1;
      end
    end
  end

  // Next-value logic for the fetch redirect sequencer
  always_comb begin
    next_state = state;
    next_fetch_redirect = 1'b0;
    next_vector_addr = vector_addr;
    next_reset_fetch = 1'b0;
    next_irq_taken = '0;
    next_fuse_held = fuse_held;
    next_settle_cnt = settle_cnt;
    case (state)
      // Wait until both synchroniser flops hold the fuse level, not their reset value
      st_reset: begin
        if (settle_cnt == `VEC_FUSE_SETTLE) begin
          // Second flop now valid: capture the fuse once
          next_state = st_vector;
          next_fuse_held = fuse_sync;
        end else begin
          // Still filling the synchroniser
          next_settle_cnt = settle_cnt + 2'h1;
        end
      end
      // Reset vector goes out before any interrupt is looked at
      st_vector: begin
        next_state = st_idle;
        next_fetch_redirect = 1'b1;
        next_reset_fetch = 1'b1;
        if (fuse_held == `VEC_FUSE_UNPROGRAMMED) begin
          next_vector_addr = `VEC_RESET_ADDR;
        end else begin
          next_vector_addr = BOOT_START;
        end
      end
      // Interrupt acceptance: only an enabled, pending source redirects
      st_idle: begin
        if (irq_accept && win_any) begin
          next_fetch_redirect = 1'b1;
          next_irq_taken = irq_vec_t'(1) << win_idx;
          // Slot offset is table start plus index, table in order of sources
          if (vector_table_select) begin
            next_vector_addr = BOOT_START + `VEC_TABLE_BASE + 12'(win_idx);
          end else begin
            next_vector_addr = `VEC_TABLE_BASE + 12'(win_idx);
          end
        end
      end
      default: begin
        next_state = st_reset;
        next_settle_cnt = 2'h0;
      end
    endcase
  end

  // State and output registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_reset;
      fetch_redirect <= 1'b0;
      vector_addr <= `VEC_RESET_ADDR;
      reset_fetch <= 1'b0;
      irq_taken <= '0;
      fuse_held <= `VEC_FUSE_UNPROGRAMMED;
      settle_cnt <= 2'h0;
    end else begin
      state <= next_state;
      fetch_redirect <= next_fetch_redirect;
      vector_addr <= next_vector_addr;
      reset_fetch <= next_reset_fetch;
      irq_taken <= next_irq_taken;
      fuse_held <= next_fuse_held;
      settle_cnt <= next_settle_cnt;
    end
  end

  // Reset redirect is loaded on the fourth edge after release and seen at the fifth
  sequence s_reset_release;
    !$past(rst_n) ##0 rst_n;
  endsequence
  a_reset_first_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(reset_fetch) |-> fetch_redirect ##1 !reset_fetch)
    else $error("reset fetch not a single redirect");
  a_reset_zero_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_fetch && fuse_held |-> vector_addr == `VEC_RESET_ADDR)
    else $error("unprogrammed fuse reset address wrong");
  a_reset_boot_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_fetch && !fuse_held |-> vector_addr == BOOT_START)
    else $error("programmed fuse reset address wrong");
  a_irq_low_table: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == st_idle && irq_accept && win_any && !vector_table_select
    |=> vector_addr == `VEC_TABLE_BASE + 12'($past(win_idx)))
    else $error("application table address wrong");
  a_irq_boot_table: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == st_idle && irq_accept && win_any && vector_table_select
    |=> vector_addr == BOOT_START + `VEC_TABLE_BASE + 12'($past(win_idx)))
    else $error("boot table address wrong");
  a_irq_only_pending: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fetch_redirect && !reset_fetch |-> ($past(irq_pending) & irq_taken) != '0)
    else $error("vector taken for a source not pending");
  a_irq_priority: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fetch_redirect && !reset_fetch
    |-> ((irq_taken - 1'b1) & $past(irq_pending)) == '0)
    else $error("lower numbered request was skipped");
  a_ext_zero_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_taken[0] && !$past(vector_table_select) |-> vector_addr == 12'h001)
    else $error("external zero slot wrong");
  a_last_slot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_taken[24] && !$past(vector_table_select) |-> vector_addr == 12'h019)
    else $error("self program ready slot wrong");
  a_no_irq_before_reset: assert property (@(posedge sys_clk)
    s_reset_release |-> !fetch_redirect [*4] ##1 reset_fetch)
    else $error("reset redirect not fourth edge after release");

  // Core accepting while idle with a request pending
  sequence s_idle_accept;
    state == st_idle && irq_accept && win_any;
  endsequence
  // Core accepting while idle with nothing pending
  sequence s_empty_accept;
    state == st_idle && irq_accept && !win_any;
  endsequence
  a_accept_redirects: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_idle_accept |=> fetch_redirect && !reset_fetch)
    else $error("accepted request gave no redirect");
  a_empty_accept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_empty_accept |=> !fetch_redirect)
    else $error("redirect with nothing pending");
  // Accepts while the fuse settles must be ignored
  a_hold_in_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == st_reset |=> !fetch_redirect)
    else $error("redirect while fuse settles");
  a_reset_alone: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_fetch |-> fetch_redirect && irq_taken == '0)
    else $error("interrupt reported with reset redirect");
  a_taken_onehot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fetch_redirect && !reset_fetch |-> $onehot(irq_taken))
    else $error("taken source not one-hot");
  a_taken_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !fetch_redirect |-> irq_taken == '0 && !reset_fetch)
    else $error("taken source without redirect");
  // Fuse is captured from the second flop only after it has filled
  a_fuse_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == st_reset && settle_cnt == `VEC_FUSE_SETTLE |=> fuse_held == $past(fuse_sync))
    else $error("fuse captured before synchroniser settled");

  // Every table entry lands at its own slot, in either table position
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_slot
    a_slot_offset: assert property (@(posedge sys_clk) disable iff (!rst_n)
      irq_taken[g] |-> vector_addr == (($past(vector_table_select) ? BOOT_START : 12'h000)
        + `VEC_TABLE_BASE + 12'(g)))
      else $error("interrupt slot address wrong");
  end

endmodule : reset_interrupt_vector_select

//--- dv/core_fetch_model.sv
// Peripheral request flags as seen by the vector generator
`timescale 1ns/100ps

module core_fetch_model (
  input wire logic sys_clk, // Core clock
  input wire vector_select_pkg::irq_vec_t irq_taken, // Source reported taken
  output vector_select_pkg::irq_vec_t irq_pending // Enabled and flagged requests
);
  import vector_select_pkg::*;
  irq_vec_t flags = '0; // Raised flags waiting for service

  // Drive the pending lines straight from the flags
  assign irq_pending = flags;

  // A peripheral raises its flag here
  task automatic post(input irq_vec_t mask);
    flags = flags | mask;
  endtask : post

  // A taken flag is cleared before the next sampling edge
  always @(negedge sys_clk) begin
    flags = flags & ~irq_taken;
  end
endmodule : core_fetch_model

//--- dv/testbench.sv
// Self-checking bench for the reset and interrupt vector address generator
`timescale 1ns/100ps

module testbench;
  import vector_select_pkg::*;
  localparam logic [11:0] BOOT = 12'hC00; // Boot section start used here
  logic sys_clk, rst_n, boot_reset_select_fuse, vector_table_select, irq_accept;
  logic fetch_redirect, reset_fetch; // Redirect pulses
  irq_vec_t irq_pending, irq_taken; // Request and taken lines
  vec_addr_t vector_addr; // Redirect target
  int error_cnt, comparisons, n, m; // Counters and scratch

  reset_interrupt_vector_select #(.NUM_SRC(25), .BOOT_START(BOOT))
    reset_interrupt_vector_select_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .boot_reset_select_fuse(boot_reset_select_fuse), .vector_table_select(vector_table_select),
    .irq_pending(irq_pending), .irq_accept(irq_accept), .fetch_redirect(fetch_redirect),
    .vector_addr(vector_addr), .reset_fetch(reset_fetch), .irq_taken(irq_taken));
  core_fetch_model core_fetch_model_i (.sys_clk(sys_clk), .irq_taken(irq_taken),
    .irq_pending(irq_pending));

  // Free-running core clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Compare an address result
  task automatic chk_addr(input vec_addr_t got, input vec_addr_t exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t addr got %h exp %h", $time, got, exp);
    end
  endtask : chk_addr

  // Compare a flag or one-hot result
  task automatic chk_bits(input irq_vec_t got, input irq_vec_t exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t bits got %h exp %h", $time, got, exp);
    end
  endtask : chk_bits

  // Reset with a fuse level, optionally with a request waiting during reset
  task automatic do_reset(input logic fuse, input logic early);
    @(negedge sys_clk);
    rst_n = 1'b0;
    boot_reset_select_fuse = fuse;
    irq_accept = early;
    core_fetch_model_i.post(irq_vec_t'(early));
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    n = 0;
    while (fetch_redirect !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk_bits(irq_vec_t'(n), 25'h0000004);
    chk_bits(irq_vec_t'(reset_fetch), 25'h0000001);
    chk_addr(vector_addr, fuse ? 12'h000 : BOOT);
    @(negedge sys_clk);
    irq_accept = 1'b0;
  endtask : do_reset

  // Raise requests and accept until all are served, lowest number first
  task automatic take(input irq_vec_t mask, input logic sel);
    int q[$]; // Expected sources in service order
    int k; // Source expected at this redirect
    for (int b = 0; b < 25; b++) begin
      if (mask[b]) q.push_back(b);
    end
    @(negedge sys_clk);
    core_fetch_model_i.post(mask);
    vector_table_select = sel;
    irq_accept = 1'b1;
    while (q.size() > 0) begin
      k = q.pop_front();
      @(posedge sys_clk);
      #1;
      chk_addr(vector_addr, (sel ? BOOT : 12'h000) + 12'h001 + 12'(k));
      chk_bits(irq_taken, 25'h0000001 << k);
      chk_bits(irq_vec_t'({fetch_redirect, reset_fetch}), 25'h0000002);
    end
    @(negedge sys_clk);
    irq_accept = 1'b0;
  endtask : take

  // Report the counts and end the run
  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // Cut a hang short
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    boot_reset_select_fuse = 1'b1;
    vector_table_select = 1'b0;
    irq_accept = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    m = $urandom(46923);
    do_reset(1'b1, 1'b0);
    for (int s = 0; s < 25; s++) take(25'h0000001 << s, m[s]);
    repeat (4) take(irq_vec_t'($urandom), 1'($urandom));
    take('0, 1'b0);
    chk_bits(irq_vec_t'(fetch_redirect), '0);
    chk_bits(irq_taken, '0);
    do_reset(1'b0, 1'b1);
    take(25'h0000001, 1'b0);
    take(25'h0000003, 1'b1);
    print_verdict();
  end
endmodule : testbench
